// ### omc_pkg.sv
// Package of constants and types for the operating mode controller.
package omc_pkg;

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam logic [11:0] OMC_ADDR_SYSCTL1 = 12'h000;
    localparam logic [11:0] OMC_ADDR_SYSCTL2 = 12'h004;
    localparam logic [11:0] OMC_ADDR_CONFIG  = 12'h008;
    localparam logic [11:0] OMC_ADDR_STATUS  = 12'h00C;

    // Control register one.
    localparam int OMC_C1_SLEEP = 0;
    // Control register two.
    localparam int OMC_C2_WDVAL_LO   = 0;
    localparam int OMC_C2_SLEEP_PERM = 2;
    localparam int OMC_C2_WDRESET    = 3;
    localparam int OMC_C2_PORSTAT    = 4;
    // Configuration register.
    localparam int OMC_CF_WAKE_CHG_EN  = 0;
    localparam int OMC_CF_EXT_RST_EN   = 1;
    localparam int OMC_CF_SLP_CNT_EN   = 2;
    localparam int OMC_CF_TMR_START    = 3;
    localparam int OMC_CF_SLD_START    = 4;
    localparam int OMC_CF_WDOG_INHIBIT = 5;
    localparam int OMC_CF_SLP_CNT_LO   = 8;
    localparam int OMC_CF_SLP_CNT_W    = 16;

    // ****************************************************************
    // Reset values and timing
    // ****************************************************************
    localparam logic [31:0] OMC_CONFIG_RST      = 32'h0000_0000;
    localparam logic [15:0] OMC_SLP_CNT_RST     = 16'h0100;
    localparam int          OMC_RST_HOLD_CYC    = 12;
    localparam int          OMC_OSC_START_CYC   = 64;
    localparam logic [3:0]  OMC_RST_HOLD_LAST   = 4'(OMC_RST_HOLD_CYC - 1);
    localparam logic [7:0]  OMC_OSC_START_LAST  = 8'(OMC_OSC_START_CYC - 1);

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic [2:0]
    {
        OMC_ST_RESET   = 3'b000,
        OMC_ST_ACTIVE  = 3'b001,
        OMC_ST_STANDBY = 3'b010,
        OMC_ST_SLEEP   = 3'b011,
        OMC_ST_WAKE    = 3'b100
    } omc_state_e;

    typedef struct packed
    {
        logic cpu_clk_en;
        logic cpu_rst;
        logic sys_rst;
        logic osc_en;
        logic presc_en;
        logic periph_en;
        logic timer_en;
        logic sld_en;
        logic debounce_en;
        logic wake_chg_arm;
    } omc_ctrl_s;

endpackage : omc_pkg

// ### omc_top.sv
// Operating mode controller: active, standby and sleep sequencing over APB.
//
// Notes on behaviour
// - Halt instruction moves the device from active to standby.
// - Standby keeps regulator, oscillator, watchdog, interrupts, timers running.
// - Standby stops the instruction clock; the processor stops.
// - Registers, RAM and pins keep their values throughout standby.
// - Standby ends on a watchdog or enabled external reset, or an enabled interrupt request.
// - A reset in active mode sends the device into reset.
// - Writing the sleep bit in control register one enters sleep once sleep permit is set.
// - Sleep stops the oscillator; only the regulator stays on.
// - Sleep stops peripherals and holds processor and functions in reset.
// - Sleep ends only on enabled port change, external reset or counter expiry.
// - Wake from sleep passes through reset, restoring reset values.
// - Reset holds through sleep and an oscillator start-up interval.
// - Wake clears the sleep flag but keeps sleep permit.
// - Sleep permit reads zero after power-up, one after wake.
// - Prescaler and clock divider run in active and standby, stop in sleep.
// - Timer runs in standby only if started before; stopped in sleep.
// - Supply level detector starts only in active; off in sleep.
// - Port and reset debouncing work in active and standby only.
// - Wake on port change acts only in sleep under enable.
// - Any reset source holds system reset twelve cycles, processor too.
// - Only power-on reset clears sleep permit and power-on-only bits.
`timescale 1ns/1ps

module omc_top
    import omc_pkg::*;
(
    input  wire logic        clk_sys_i,
    input  wire logic        reset_n_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [11:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    input  wire logic        halt_i,
    input  wire logic        irq_req_i,
    input  wire logic        ext_rst_i,
    input  wire logic        wdog_rst_i,
    input  wire logic        port_change_i,
    input  wire logic [1:0]  wdog_val_i,
    output omc_pkg::omc_ctrl_s ctrl_o,
    output omc_pkg::omc_state_e mode_o,
    output logic             wdog_clear_o
);
    import omc_pkg::*;

    // ****************************************************************
    // State
    // ****************************************************************
    omc_state_e  state_q;
    omc_state_e  state_d;
    logic [3:0]  hold_q;
    logic [7:0]  osc_q;
    logic [15:0] slp_cnt_q;
    logic [31:0] config_q;
    logic        sleep_flag_q;
    logic        sleep_perm_q;
    logic        por_stat_q;
    logic        timer_run_q;
    logic        sld_run_q;
    logic        wdog_clr_q;
    logic [31:0] rdata_q;
    logic        ready_q;
    logic        err_q;
    omc_ctrl_s   ctrl_q;

    // ****************************************************************
    // Bus decode
    // ****************************************************************
    wire setup_w   = psel_i && !penable_i;
    wire access_w  = psel_i && penable_i && ready_q;
    wire wr_w      = access_w && pwrite_i;
    wire hit_c1    = paddr_i == OMC_ADDR_SYSCTL1;
    wire hit_c2    = paddr_i == OMC_ADDR_SYSCTL2;
    wire hit_cf    = paddr_i == OMC_ADDR_CONFIG;
    wire hit_st    = paddr_i == OMC_ADDR_STATUS;
    wire hit_any   = hit_c1 || hit_c2 || hit_cf || hit_st;
    wire wr_c1     = wr_w && hit_c1;
    wire wr_c2     = wr_w && hit_c2;
    wire wr_cf     = wr_w && hit_cf && (state_q == OMC_ST_ACTIVE);

    wire in_active  = state_q == OMC_ST_ACTIVE;
    wire in_standby = state_q == OMC_ST_STANDBY;
    wire in_sleep   = state_q == OMC_ST_SLEEP;

    // Software writes only land while the processor runs; reset holds them off.
    wire sleep_req  = wr_c1 && in_active && pwdata_i[OMC_C1_SLEEP]
                      && sleep_perm_q;

    wire wake_chg   = in_sleep && config_q[OMC_CF_WAKE_CHG_EN]
                      && port_change_i;
    wire wake_ext   = in_sleep && config_q[OMC_CF_EXT_RST_EN] && ext_rst_i;
    wire wake_cnt   = in_sleep && config_q[OMC_CF_SLP_CNT_EN] && (slp_cnt_q == 16'h0000);
    wire wake_w     = wake_chg || wake_ext || wake_cnt;

    // External reset through debouncing is only honoured awake; the watchdog
    // is frozen in sleep so its request is ignored there.
    wire awake_rst  = (in_active || in_standby)
                      && ((config_q[OMC_CF_EXT_RST_EN] && ext_rst_i) || wdog_rst_i);

    wire [31:0] c2_rd = {27'h000_0000, por_stat_q, 1'b0, sleep_perm_q, wdog_val_i};
    wire [31:0] st_rd = {28'h000_0000, sleep_flag_q, state_q};
    wire [31:0] rd_mux = hit_c1 ? {31'h0000_0000, sleep_flag_q} :
                         hit_c2 ? c2_rd :
                         hit_cf ? config_q :
                         hit_st ? st_rd : 32'h0000_0000;

    // ****************************************************************
    // Mode sequencer
    // ****************************************************************
    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            OMC_ST_RESET:
                if (hold_q == OMC_RST_HOLD_LAST)
                    state_d = OMC_ST_ACTIVE;
            OMC_ST_ACTIVE:
                if (awake_rst)
                    state_d = OMC_ST_RESET;
                else if (sleep_req)
                    state_d = OMC_ST_SLEEP;
                else if (halt_i)
                    state_d = OMC_ST_STANDBY;
            OMC_ST_STANDBY:
                if (awake_rst)
                    state_d = OMC_ST_RESET;
                else if (irq_req_i)
                    state_d = OMC_ST_ACTIVE;
            OMC_ST_SLEEP:
                if (wake_w)
                    state_d = OMC_ST_WAKE;
            OMC_ST_WAKE:
                if (osc_q == OMC_OSC_START_LAST)
                    state_d = OMC_ST_RESET;
            default:
                state_d = OMC_ST_RESET;
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            state_q <= OMC_ST_RESET;
            hold_q  <= 4'h0;
            osc_q   <= 8'h00;
        end
        else
        begin
            state_q <= state_d;
            hold_q  <= (state_q == OMC_ST_RESET) ? hold_q + 4'h1 : 4'h0;
            osc_q   <= (state_q == OMC_ST_WAKE) ? osc_q + 8'h01 : 8'h00;
        end
    end

    // ****************************************************************
    // Sleep counter and permit latch
    // ****************************************************************
    always_ff @(posedge clk_sys_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            slp_cnt_q <= OMC_SLP_CNT_RST;
        else if (!in_sleep)
            slp_cnt_q <= config_q[OMC_CF_SLP_CNT_LO +: OMC_CF_SLP_CNT_W];
        else if (slp_cnt_q != 16'h0000)
            slp_cnt_q <= slp_cnt_q - 16'h0001;
    end

    // The permit latch and the power-on flag only see the pin reset, which
    // stands for power-on; internal resets and wake leave them alone.
    always_ff @(posedge clk_sys_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            sleep_perm_q <= 1'b0;
            por_stat_q   <= 1'b1;
        end
        else
        begin
            if (wr_c2 && in_active)
                sleep_perm_q <= pwdata_i[OMC_C2_SLEEP_PERM];
            if (wr_c1 && in_active)
                por_stat_q <= 1'b0;
        end
    end

    // ****************************************************************
    // Resettable control registers
    // ****************************************************************
    // Everything here except the sleep flag, which only wake clears, returns to reset value
    // whenever the sequencer is in reset, so a wake behaves like a reset apart from the permit latch and the power-on flag.
    wire sys_rst_w = (state_q == OMC_ST_RESET) || in_sleep
                     || (state_q == OMC_ST_WAKE);

    always_ff @(posedge clk_sys_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            config_q     <= OMC_CONFIG_RST;
            sleep_flag_q <= 1'b0;
            timer_run_q  <= 1'b0;
            sld_run_q    <= 1'b0;
            wdog_clr_q   <= 1'b0;
        end
        else
        begin
            wdog_clr_q <= wr_c2 && in_active && pwdata_i[OMC_C2_WDRESET];
            if (sleep_req)
                sleep_flag_q <= 1'b1;
            else if (state_q == OMC_ST_WAKE)
                sleep_flag_q <= 1'b0;
            if (state_q == OMC_ST_RESET)
            begin
                config_q    <= OMC_CONFIG_RST;
                timer_run_q <= 1'b0;
                sld_run_q   <= 1'b0;
            end
            else if (wr_cf)
            begin
                // Wake enables survive sleep since writes never occur then.
                config_q    <= pwdata_i;
                timer_run_q <= pwdata_i[OMC_CF_TMR_START];
                sld_run_q   <= pwdata_i[OMC_CF_SLD_START];
            end
        end
    end

    // ****************************************************************
    // Function enables
    // ****************************************************************
    omc_ctrl_s ctrl_d;
    always_comb
    begin
        ctrl_d              = '0;
        ctrl_d.cpu_clk_en   = in_active;
        ctrl_d.cpu_rst      = sys_rst_w;
        ctrl_d.sys_rst      = sys_rst_w;
        ctrl_d.osc_en       = !in_sleep;
        ctrl_d.presc_en     = in_active || in_standby;
        ctrl_d.periph_en    = in_active || in_standby;
        ctrl_d.timer_en     = (in_active || in_standby) && timer_run_q;
        ctrl_d.sld_en       = in_active && sld_run_q;
        ctrl_d.debounce_en  = in_active || in_standby;
        ctrl_d.wake_chg_arm = in_sleep && config_q[OMC_CF_WAKE_CHG_EN];
    end

    // ****************************************************************
    // APB slave
    // ****************************************************************
    always_ff @(posedge clk_sys_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            ready_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            err_q   <= 1'b0;
            ctrl_q  <= '0;
        end
        else
        begin
            ready_q <= setup_w;
            err_q   <= setup_w && !hit_any;
            if (setup_w)
                rdata_q <= pwrite_i ? 32'h0000_0000 : rd_mux;
            ctrl_q  <= ctrl_d;
        end
    end

    assign prdata_o     = rdata_q;
    assign pready_o     = ready_q;
    assign pslverr_o    = err_q;
    assign ctrl_o       = ctrl_q;
    assign mode_o       = state_q;
    assign wdog_clear_o = wdog_clr_q;

endmodule // omc_top

// ### omc_top_asserts.sv
// Assertion checker bound to the operating mode controller top.
`timescale 1ns/1ps

module omc_top_asserts
    import omc_pkg::*;
(
    input wire logic                clk_sys_i,
    input wire logic                reset_n_i,
    input wire logic                psel_i,
    input wire logic                penable_i,
    input wire logic                pwrite_i,
    input wire logic                halt_i,
    input wire logic                irq_req_i,
    input wire logic                ext_rst_i,
    input wire logic                wdog_rst_i,
    input wire omc_pkg::omc_ctrl_s  ctrl_o,
    input wire omc_pkg::omc_state_e mode_o
);
    // ****************************************************************
    // Helpers
    // ****************************************************************
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!reset_n_i);

    // The start-up wait is too long for a repetition, so it is counted.
    logic [6:0] wake_cnt_q;
    logic [6:0] wake_cnt_d;
    // Counts consecutive reset cycles so the hold length can be checked without a repetition.
    logic [3:0] rst_cnt_q;
    wire logic  awake  = (mode_o == OMC_ST_ACTIVE) || (mode_o == OMC_ST_STANDBY);
    wire logic  wr_acc = psel_i && penable_i && pwrite_i;
    assign wake_cnt_d = (mode_o == OMC_ST_WAKE) ? wake_cnt_q + 7'h01 : 7'h00;
    always_ff @(posedge clk_sys_i or negedge reset_n_i)
        if (!reset_n_i)
            wake_cnt_q <= 7'h00;
        else
            wake_cnt_q <= wake_cnt_d;
    always_ff @(posedge clk_sys_i or negedge reset_n_i)
        if (!reset_n_i)
            rst_cnt_q <= 4'h0;
        else
            rst_cnt_q <= (mode_o == OMC_ST_RESET) ? rst_cnt_q + 4'h1 : 4'h0;

    // ****************************************************************
    // Properties
    // ****************************************************************
    property p_halt;
        mode_o == OMC_ST_ACTIVE && halt_i && !ext_rst_i && !wdog_rst_i && !wr_acc
            |=> mode_o == OMC_ST_STANDBY;
    endproperty
    a_halt: assert property (p_halt) else $error("halt missed");
    property p_stby_ctrl;
        mode_o == OMC_ST_STANDBY |=> !ctrl_o.cpu_clk_en && ctrl_o.osc_en && ctrl_o.presc_en
            && ctrl_o.periph_en && ctrl_o.debounce_en;
    endproperty
    a_stby_ctrl: assert property (p_stby_ctrl)
        else $error("standby ctrl");
    property p_stby_exit;
        mode_o == OMC_ST_STANDBY && irq_req_i && !ext_rst_i && !wdog_rst_i
            |=> mode_o == OMC_ST_ACTIVE;
    endproperty
    a_stby_exit: assert property (p_stby_exit) else $error("irq missed");
    property p_rst_hold;
        awake && wdog_rst_i |=> mode_o == OMC_ST_RESET
            ##12 (mode_o == OMC_ST_ACTIVE && rst_cnt_q == 4'hC);
    endproperty
    a_rst_hold: assert property (p_rst_hold) else $error("reset hold");
    property p_rst_ctrl;
        mode_o == OMC_ST_RESET |=> ctrl_o.sys_rst && ctrl_o.cpu_rst && !ctrl_o.cpu_clk_en;
    endproperty
    a_rst_ctrl: assert property (p_rst_ctrl) else $error("reset ctrl");
    property p_sleep_ctrl;
        mode_o == OMC_ST_SLEEP |=> !ctrl_o.osc_en && !ctrl_o.presc_en && !ctrl_o.periph_en
            && !ctrl_o.timer_en && !ctrl_o.sld_en && !ctrl_o.debounce_en && ctrl_o.sys_rst;
    endproperty
    a_sleep_ctrl: assert property (p_sleep_ctrl)
        else $error("sleep ctrl");
    property p_wake_arm;
        mode_o != OMC_ST_SLEEP |=> !ctrl_o.wake_chg_arm;
    endproperty
    a_wake_arm: assert property (p_wake_arm) else $error("wake armed");
    property p_wake_len;
        mode_o == OMC_ST_WAKE ##1 mode_o != OMC_ST_WAKE
            |-> wake_cnt_q == 7'(OMC_OSC_START_CYC) && mode_o == OMC_ST_RESET && ctrl_o.sys_rst;
    endproperty
    a_wake_len: assert property (p_wake_len) else $error("start-up wait");
    c_stby_wake: cover property (mode_o == OMC_ST_STANDBY ##1 mode_o == OMC_ST_ACTIVE);
    c_sleep_wake: cover property (mode_o == OMC_ST_SLEEP ##1 mode_o == OMC_ST_WAKE);
    c_wdog_rst: cover property (awake && wdog_rst_i);
endmodule // omc_top_asserts

bind omc_top omc_top_asserts omc_top_asserts_inst (
    .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .halt_i(halt_i), .irq_req_i(irq_req_i), .ext_rst_i(ext_rst_i),
    .wdog_rst_i(wdog_rst_i), .ctrl_o(ctrl_o), .mode_o(mode_o)
);

// ### omc_top_tb.sv
// Self-checking testbench for the operating mode controller.
`timescale 1ns/1ps

module omc_top_tb;
    import omc_pkg::*;

    // Event pulses: 0 halt, 1 interrupt, 2 external reset, 3 watchdog, 4 port change.
    logic [4:0]  evt;
    logic        clk_sys_i, reset_n_i, psel_i, penable_i, pwrite_i;
    logic        pready_o, pslverr_o, wdog_clear_o;
    logic [11:0] paddr_i;
    logic [31:0] pwdata_i, prdata_o, cfg;
    logic [1:0]  wdog_val_i;
    omc_ctrl_s   ctrl_o;
    omc_state_e  mode_o;
    logic [32:0] exp_q[$];
    logic [32:0] exp_e;
    int          err_count, num_checks;

    omc_top omc_top_inst (
        .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .psel_i(psel_i), .penable_i(penable_i),
        .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o), .halt_i(evt[0]), .irq_req_i(evt[1]),
        .ext_rst_i(evt[2]), .wdog_rst_i(evt[3]), .port_change_i(evt[4]),
        .wdog_val_i(wdog_val_i), .ctrl_o(ctrl_o), .mode_o(mode_o), .wdog_clear_o(wdog_clear_o)
    );

    // ****************************************************************
    // Tasks
    // ****************************************************************
    task automatic finish_test;
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic give_up;
        err_count++;
        finish_test();
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("BAD %0t seen %h exp %h", $time, seen, exp);
        end
    endtask

    // Ready is sampled at the rising edge; the request is released at that same edge.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       input logic [32:0] e);
        int n;
        n = 0;
        exp_q.push_back(e);
        @(posedge clk_sys_i);
        psel_i   <= 1'b1;
        pwrite_i <= wr;
        paddr_i  <= a;
        pwdata_i <= d;
        @(posedge clk_sys_i);
        penable_i <= 1'b1;
        do
        begin
            @(posedge clk_sys_i);
            n++;
        end
        while (pready_o !== 1'b1 && n < 20);
        if (n >= 20)
            give_up();
        psel_i    <= 1'b0;
        penable_i <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000, {1'b0, e});
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 33'h0_0000_0000);
    endtask

    task automatic pulse(input int b);
        @(posedge clk_sys_i);
        evt[b] <= 1'b1;
        @(posedge clk_sys_i);
        evt[b] <= 1'b0;
    endtask

    task automatic wait_mode(input omc_state_e m);
        int n;
        n = 0;
        while (mode_o !== m && n < 300)
        begin
            @(negedge clk_sys_i);
            n++;
        end
        if (n >= 300)
            give_up();
    endtask

    always @(posedge clk_sys_i)
        if (psel_i && penable_i && pready_o === 1'b1)
        begin
            exp_e = exp_q.pop_front();
            check({31'h0, pslverr_o}, {31'h0, exp_e[32]});
            if (!pwrite_i)
                check(prdata_o, exp_e[31:0]);
        end

    // ****************************************************************
    // Stimulus
    // ****************************************************************
    initial
    begin
        clk_sys_i = 1'b0;
        forever
            #5 clk_sys_i = ~clk_sys_i;
    end

    initial
    begin
        {reset_n_i, psel_i, penable_i, pwrite_i, evt} = '0;
        {paddr_i, pwdata_i, wdog_val_i} = '0;
        void'($urandom(2));
        repeat (6) @(posedge clk_sys_i);
        reset_n_i  <= 1'b1;
        wdog_val_i <= 2'($urandom);
        wait_mode(OMC_ST_ACTIVE);
        rd(OMC_ADDR_SYSCTL2, 32'h0000_0010 | 32'(wdog_val_i));
        cfg = $urandom & 32'h00FF_FF1F;
        wr(OMC_ADDR_CONFIG, cfg);
        rd(OMC_ADDR_CONFIG, cfg);
        apb(1'b0, 12'h010, 32'h0000_0000, {1'b1, 32'h0000_0000});
        wr(OMC_ADDR_SYSCTL1, 32'h0000_0001);
        rd(OMC_ADDR_SYSCTL1, 32'h0000_0000);
        rd(OMC_ADDR_SYSCTL2, 32'(wdog_val_i));
        $display("test registers done");
        wr(OMC_ADDR_SYSCTL2, 32'h0000_0004);
        pulse(0);
        wait_mode(OMC_ST_STANDBY);
        @(negedge clk_sys_i);
        check(32'(ctrl_o) & 32'h0000_03FB, 32'h0000_0072 | {28'h0, cfg[3], 3'h0});
        rd(OMC_ADDR_CONFIG, cfg);
        pulse(1);
        wait_mode(OMC_ST_ACTIVE);
        rd(OMC_ADDR_CONFIG, cfg);
        pulse(0);
        wait_mode(OMC_ST_STANDBY);
        pulse(3);
        wait_mode(OMC_ST_RESET);
        wait_mode(OMC_ST_ACTIVE);
        rd(OMC_ADDR_CONFIG, 32'h0000_0000);
        rd(OMC_ADDR_SYSCTL2, 32'h0000_0004 | 32'(wdog_val_i));
        $display("test standby done");
        for (int k = 0; k < 3; k++)
        begin
            wdog_val_i <= 2'($urandom);
            cfg = {8'h00, 16'h0006 + 16'($urandom % 8), 5'h00, 3'(1 << k)};
            wr(OMC_ADDR_CONFIG, cfg);
            pulse(4);
            repeat (3) @(negedge clk_sys_i);
            check(32'(mode_o), 32'(OMC_ST_ACTIVE));
            wr(OMC_ADDR_SYSCTL1, 32'h0000_0001);
            wait_mode(OMC_ST_SLEEP);
            repeat (3) @(negedge clk_sys_i);
            check({19'h0, mode_o, ctrl_o}, {19'h0, OMC_ST_SLEEP, 10'h180|10'(k==0)});
            if (k < 2)
                pulse(k == 0 ? 4 : 2);
            wait_mode(OMC_ST_WAKE);
            wait_mode(OMC_ST_ACTIVE);
            rd(OMC_ADDR_SYSCTL1, 32'h0000_0000);
            rd(OMC_ADDR_SYSCTL2, 32'h0000_0004 | 32'(wdog_val_i));
            rd(OMC_ADDR_CONFIG, 32'h0000_0000);
        end
        $display("test sleep done");
        finish_test();
    end
endmodule // omc_top_tb
